// File: design/tef_formatter.sv
// trace entry formatter: builds trace buffer lines from core records
// What this block does
// R1: normal/dedup info byte: type 7-6, comparator 3, event 2, overflow 0, rest zero.
// R2: comparator flag is one only for comparator D caused entries.
// R3: external event flag is one only when the event input caused the entry.
// R4: overflow flag in bit 0 when a stamp counter overflow caused the entry.
// R5: entry type 00 event, 01 vector, 10 branch source, 11 branch destination.
// R6: dedup mode drops a source entry equal to the previous stored source.
// R7: dedup mode keeps repeated destination and vector entries.
// R8: dedup mode uses the normal line layout and info byte.
// R9: detail mode records address, data and info of every access.
// R10: detail line: data 7-4, info 3, address 2-0, counter plus 2.
// R11: stamp line follows: stamp 7-6, reserved 5-4, info 3, pc 2-0.
// R12: a valid pc in the stamp cycle is stored and flagged.
// R13: stamp line written only if no access follows next cycle.
// R14: access plus stamp line advances the counter by 4.
// R15: stamp counter resets only when a stamp line is written.
// R16: first data byte at lane chosen by low address bits, wrapping.
// R17: detail info byte: size 7-6, direction 5, bits 4-0 zero.
// R18: stamp info: 7-4 zero, comparator 3, pc valid 2, bit 1 one, overflow 0.
// R19: size codes 00 8-bit, 01 16-bit, 10 24-bit, 11 32-bit.
// R20: direction flag 0 on write, 1 on read.
// R21: two entries per line in normal modes, counter advances per entry.
// R22: event coinciding with a flow entry gives one entry with event flag.
// R23: untouched data lanes of a detail line hold zero.
//
// Chosen here: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/1ps
`include "tef_map.svh"
module tef_formatter
    import tef_pkg::*;
#(
    parameter int CNT_W = 8,
    parameter int TS_W  = 16
) (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rst_n,
    // axi4-lite slave
    input  wire logic [11:0] s_awaddr,
    input  wire logic        s_awvalid,
    output logic             s_awready,
    input  wire logic [31:0] s_wdata,
    input  wire logic [3:0]  s_wstrb,
    input  wire logic        s_wvalid,
    output logic             s_wready,
    output logic [1:0]       s_bresp,
    output logic             s_bvalid,
    input  wire logic        s_bready,
    input  wire logic [11:0] s_araddr,
    input  wire logic        s_arvalid,
    output logic             s_arready,
    output logic [31:0]      s_rdata,
    output logic [1:0]       s_rresp,
    output logic             s_rvalid,
    input  wire logic        s_rready,
    // core record stream
    input  wire tef_cof_t    cof_in,
    input  wire tef_acc_t    acc_in,
    input  wire logic        pc_valid,
    input  wire logic [23:0] pc_value,
    input  wire logic        ts_cmp_match,
    input  wire logic        ts_ovf,
    // trace line output
    output tef_line_t        line_out
);
    // the line counter and stamp fields of the line and count words are fixed width
    if (CNT_W != 8 || TS_W != 16) begin : g_bad_param
        $error("tef_formatter: unsupported parameter values");
    end

    // ---------------- register file ----------------
    logic [1:0]  mode_q;
    logic        stamp_en_q;
    logic        aw_hold_q, w_hold_q;
    logic [11:0] aw_addr_q;
    logic [31:0] w_data_q;
    logic [3:0]  w_strb_q;
    logic [CNT_W-1:0] cnt_q;
    logic [31:0] drop_cnt_q;
    logic [TS_W-1:0] ts_q;

    // address and data may arrive in either order
    assign s_awready = !aw_hold_q && !s_bvalid;
    assign s_wready  = !w_hold_q && !s_bvalid;
    assign s_bresp   = 2'h0;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            aw_hold_q <= 1'b0;
            w_hold_q  <= 1'b0;
            aw_addr_q <= 12'h000;
            w_data_q  <= 32'h0000_0000;
            w_strb_q  <= 4'h0;
            s_bvalid  <= 1'b0;
        end else begin
            if (s_awvalid && s_awready) begin
                aw_hold_q <= 1'b1;
                aw_addr_q <= s_awaddr;
            end
            if (s_wvalid && s_wready) begin
                w_hold_q <= 1'b1;
                w_data_q <= s_wdata;
                w_strb_q <= s_wstrb;
            end
            if (aw_hold_q && w_hold_q) begin
                aw_hold_q <= 1'b0;
                w_hold_q  <= 1'b0;
                s_bvalid  <= 1'b1;
            end
            if (s_bvalid && s_bready) begin
                s_bvalid <= 1'b0;
            end
        end
    end

    // control register; unmapped writes are accepted and dropped
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mode_q     <= 2'h0;
            stamp_en_q <= 1'b0;
        end else if (aw_hold_q && w_hold_q && aw_addr_q == `TEF_CTRL_OFS && w_strb_q[0]) begin
            mode_q     <= w_data_q[`TEF_CTRL_MODE_LO +: 2];
            stamp_en_q <= w_data_q[`TEF_CTRL_STAMP];
        end
    end

    // read channel, one cycle after the address is taken
    assign s_arready = !s_rvalid;
    assign s_rresp   = 2'h0;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_rvalid <= 1'b0;
            s_rdata  <= 32'h0000_0000;
        end else if (s_arvalid && s_arready) begin
            s_rvalid <= 1'b1;
            unique case (s_araddr)
                `TEF_CTRL_OFS: s_rdata <= {29'h0, stamp_en_q, mode_q};
                `TEF_STAT_OFS: s_rdata <= drop_cnt_q;
                `TEF_CNT_OFS:  s_rdata <= {ts_q, 8'h00, cnt_q};
                default:       s_rdata <= 32'h0000_0000;
            endcase
        end else if (s_rvalid && s_rready) begin
            s_rvalid <= 1'b0;
        end
    end

    // ---------------- flow entries (normal and dedup) ----------------
    logic        flow_mode;
    logic        is_dup;
    logic        flow_take;
    logic [7:0]  cof_info;
    logic [23:0] last_src_q;
    logic        last_src_v_q;
    logic [31:0] half_q;
    logic        half_full_q;

    assign flow_mode = (mode_q == TEF_MODE_NORMAL) || (mode_q == TEF_MODE_DEDUP); // R8
    // only sources are compared; destinations and vectors always pass
    assign is_dup = (mode_q == TEF_MODE_DEDUP) && (cof_in.etype == TEF_ET_SOURCE) // R6 R7
                    && last_src_v_q && (last_src_q == cof_in.addr);
    assign flow_take = flow_mode && cof_in.valid && !is_dup;
    // one record carries both flow and event, so a coincidence is one entry
    assign cof_info = {cof_in.etype, 2'b00, cof_in.cmp_match,       // R1 R2 R5 R22
                       cof_in.ext_event, 1'b0, cof_in.stamp_ovf};   // R3 R4

    // remember the last stored source address
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            last_src_q   <= 24'h000000;
            last_src_v_q <= 1'b0;
        end else if (!flow_mode) begin
            last_src_v_q <= 1'b0;
        end else if (flow_take && cof_in.etype == TEF_ET_SOURCE) begin
            last_src_q   <= cof_in.addr;
            last_src_v_q <= 1'b1;
        end
    end

    // count dropped duplicates for software
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            drop_cnt_q <= 32'h0000_0000;
        end else if (flow_mode && cof_in.valid && is_dup) begin
            drop_cnt_q <= drop_cnt_q + 32'h0000_0001;
        end
    end

    // first entry of a pair waits for its partner in the low half
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            half_q      <= 32'h0000_0000;
            half_full_q <= 1'b0;
        end else if (!flow_mode) begin
            half_full_q <= 1'b0;
        end else if (flow_take) begin
            half_q      <= {cof_info, cof_in.addr};
            half_full_q <= !half_full_q; // R21
        end
    end

    // ---------------- detail mode ----------------
    logic        det_mode;
    logic        acc_take;
    logic [31:0] lanes;
    logic [7:0]  acc_info;
    logic        pend_q;
    logic [7:0]  pend_info_q;
    logic        pend_pcv_q;
    logic [23:0] pend_pc_q;
    logic        pend_cmp_q, pend_ovf_q;
    logic        ts_write;

    assign det_mode = (mode_q == TEF_MODE_DETAIL);
    assign acc_take = det_mode && acc_in.valid; // R9
    assign acc_info = {acc_in.size, acc_in.read, 5'h00}; // R17 R19 R20

    // rotate bytes so the first lands at the lane of the low address bits
    always_comb begin
        logic [7:0] b [4];
        logic [1:0] lane;
        lane = 2'h0;
        for (int i = 0; i < 4; i++) begin
            b[i] = 8'h00;
        end
        lanes = 32'h0000_0000;
        for (int k = 0; k < 4; k++) begin
            b[k] = acc_in.data[8*(3-k) +: 8];
        end
        for (int k = 0; k < 4; k++) begin
            lane = 2'(acc_in.addr[1:0] + 2'(k)); // R16
            if (k <= int'(acc_in.size)) begin // R23
                lanes[8*(3-lane) +: 8] = b[k];
            end
        end
    end

    // stamp line waits one cycle to see whether another access follows
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pend_q      <= 1'b0;
            pend_info_q <= 8'h00;
            pend_pcv_q  <= 1'b0;
            pend_pc_q   <= 24'h000000;
            pend_cmp_q  <= 1'b0;
            pend_ovf_q  <= 1'b0;
        end else begin
            pend_q      <= acc_take && stamp_en_q;
            pend_pcv_q  <= pc_valid; // R12
            pend_pc_q   <= pc_valid ? pc_value : 24'h000000;
            pend_cmp_q  <= ts_cmp_match;
            pend_ovf_q  <= ts_ovf;
            pend_info_q <= acc_info;
        end
    end

    assign ts_write = pend_q && !acc_take && det_mode; // R13

    // stamp counter, cleared only by a stamp line
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ts_q <= 16'h0000;
        end else if (ts_write) begin
            ts_q <= 16'h0000; // R15
        end else begin
            ts_q <= ts_q + 16'h0001;
        end
    end

    // ---------------- line output and counter ----------------
    logic [7:0] ts_info;
    assign ts_info = {4'h0, pend_cmp_q, pend_pcv_q, 1'b1, pend_ovf_q}; // R18

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            line_out <= '0;
            cnt_q    <= 8'h00;
        end else begin
            line_out.valid <= 1'b0;
            if (flow_take) begin
                cnt_q <= cnt_q + 8'(`TEF_STEP_ENTRY); // R21
                if (half_full_q) begin
                    line_out.valid <= 1'b1;
                    line_out.data  <= {cof_info, cof_in.addr, half_q};
                    line_out.counter <= cnt_q + 8'(`TEF_STEP_ENTRY);
                end
            end else if (acc_take) begin
                // an access line takes 2; a stamp line adds 2 more, 4 in all
                cnt_q <= cnt_q + 8'(`TEF_STEP_LINE); // R10
                line_out.valid   <= 1'b1;
                line_out.data    <= {lanes, acc_info, acc_in.addr}; // R10
                line_out.counter <= cnt_q + 8'(`TEF_STEP_LINE);
            end else if (ts_write) begin
                cnt_q <= cnt_q + 8'(`TEF_STEP_LINE); // R14
                line_out.valid   <= 1'b1;
                line_out.data    <= {ts_q, 16'h0000, ts_info, pend_pc_q}; // R11
                line_out.counter <= cnt_q + 8'(`TEF_STEP_LINE);
            end
        end
    end

    // ---------------- assertions ----------------
    flow_info_zero_a: assert property (@(posedge clk) disable iff (!rst_n) // R1
        (flow_take && half_full_q) |=> (line_out.data[61:60] == 2'b00
                                        && line_out.data[57] == 1'b0))
        else $error("flow info byte reserved bits not zero");
    flow_pair_line_a: assert property (@(posedge clk) disable iff (!rst_n) // R21
        (flow_take && !half_full_q) |=> !line_out.valid)
        else $error("line written after single flow entry");
    dup_dropped_a: assert property (@(posedge clk) disable iff (!rst_n) // R6
        (mode_q == TEF_MODE_DEDUP && cof_in.valid && cof_in.etype == TEF_ET_SOURCE
         && last_src_v_q && last_src_q == cof_in.addr) |=> $stable(cnt_q))
        else $error("duplicate source was stored");
    dest_kept_a: assert property (@(posedge clk) disable iff (!rst_n) // R7
        (mode_q == TEF_MODE_DEDUP && cof_in.valid && cof_in.etype == TEF_ET_DEST)
        |=> cnt_q == $past(cnt_q) + 8'h01)
        else $error("destination entry not stored");
    acc_line_a: assert property (@(posedge clk) disable iff (!rst_n) // R10
        acc_take |=> (line_out.valid && line_out.data[23:0] == $past(acc_in.addr)
                      && line_out.data[28:24] == 5'h00))
        else $error("access line layout wrong");
    stamp_follow_a: assert property (@(posedge clk) disable iff (!rst_n) // R13
        (acc_take && stamp_en_q) ##1 (det_mode && !acc_in.valid)
        |=> (line_out.valid && line_out.data[25] && ts_q == 16'h0000))
        else $error("stamp line missing after lone access");
    stamp_step_a: assert property (@(posedge clk) disable iff (!rst_n) // R14
        (acc_take && stamp_en_q) ##1 (det_mode && !acc_in.valid)
        |=> cnt_q == $past(cnt_q, 2) + 8'h04)
        else $error("access plus stamp did not advance by 4");
    lane_zero_a: assert property (@(posedge clk) disable iff (!rst_n) // R23
        (acc_take && acc_in.size == 2'h0 && acc_in.addr[1:0] == 2'h0)
        |=> line_out.data[55:32] == 24'h000000)
        else $error("untouched lanes not zero");
    type_field_a: assert property (@(posedge clk) disable iff (!rst_n) // R5
        (flow_take && half_full_q) |=> line_out.data[63:62] == $past(cof_in.etype))
        else $error("entry type field wrong");
    cmp_flag_a: assert property (@(posedge clk) disable iff (!rst_n) // R2
        (flow_take && half_full_q) |=> line_out.data[59] == $past(cof_in.cmp_match))
        else $error("comparator flag wrong");
    event_flag_a: assert property (@(posedge clk) disable iff (!rst_n) // R3
        (flow_take && half_full_q) |=> line_out.data[58] == $past(cof_in.ext_event))
        else $error("external event flag wrong");
    ovf_flag_a: assert property (@(posedge clk) disable iff (!rst_n) // R4
        (flow_take && half_full_q) |=> line_out.data[56] == $past(cof_in.stamp_ovf))
        else $error("overflow flag wrong");
    acc_info_a: assert property (@(posedge clk) disable iff (!rst_n) // R17 R19 R20
        acc_take |=> line_out.data[31:24] == {$past(acc_in.size), $past(acc_in.read), 5'h00})
        else $error("access info byte wrong");
    stamp_info_a: assert property (@(posedge clk) disable iff (!rst_n) // R18
        ts_write |=> (line_out.data[31:28] == 4'h0 && line_out.data[25] == 1'b1))
        else $error("stamp info byte wrong");
    stamp_pc_a: assert property (@(posedge clk) disable iff (!rst_n) // R12
        (acc_take && stamp_en_q && pc_valid) ##1 (det_mode && !acc_in.valid)
        |=> (line_out.data[26] && line_out.data[23:0] == $past(pc_value, 2)))
        else $error("valid pc not stored on stamp line");
    stamp_run_a: assert property (@(posedge clk) disable iff (!rst_n) // R15
        acc_take |=> ts_q == $past(ts_q) + 16'h0001)
        else $error("stamp counter cleared by access line");
    b2b_suppress_a: assert property (@(posedge clk) disable iff (!rst_n) // R13
        (acc_take && stamp_en_q) ##1 acc_take |=> (line_out.valid && !line_out.data[25]))
        else $error("stamp line written between back to back accesses");
    lane_wrap_a: assert property (@(posedge clk) disable iff (!rst_n) // R16
        (acc_take && acc_in.size == 2'h3 && acc_in.addr[1:0] == 2'h1)
        |=> (line_out.data[63:56] == $past(acc_in.data[7:0])
             && line_out.data[55:48] == $past(acc_in.data[31:24])))
        else $error("data lanes not wrapped");

    cov_pair_c:   cover property (@(posedge clk) disable iff (!rst_n)
        flow_take && half_full_q);
    cov_dup_c:    cover property (@(posedge clk) disable iff (!rst_n)
        flow_mode && cof_in.valid && is_dup);
    cov_stamp_c:  cover property (@(posedge clk) disable iff (!rst_n) ts_write);
    cov_b2b_c:    cover property (@(posedge clk) disable iff (!rst_n)
        acc_take && pend_q);
    // event folded into a flow entry rather than a second entry
    cov_event_c:  cover property (@(posedge clk) disable iff (!rst_n)
        flow_take && cof_in.ext_event && cof_in.etype != TEF_ET_EVENT);
endmodule

// File: design/tef_map.svh
// offsets, field positions and counter steps of the trace entry formatter
`ifndef TEF_MAP_SVH
`define TEF_MAP_SVH

// register byte addresses
`define TEF_CTRL_OFS     12'h000
`define TEF_STAT_OFS     12'h004
`define TEF_CNT_OFS      12'h008

// control field positions
`define TEF_CTRL_MODE_LO 0
`define TEF_CTRL_STAMP   2
`define TEF_CTRL_RST     12'h000

// info byte field positions
`define TEF_INF_TYPE_LO  6
`define TEF_INF_CMP      3
`define TEF_INF_EEV      2
`define TEF_INF_PCV      2
`define TEF_INF_TSID     1
`define TEF_INF_OVF      0
`define TEF_INF_SIZE_LO  6
`define TEF_INF_DIR      5

// counter steps
`define TEF_STEP_ENTRY   1
`define TEF_STEP_LINE    2
`define TEF_STEP_STAMP   4

`endif

// File: design/tef_pkg.sv
// types of the trace entry formatter
package tef_pkg;
    typedef enum logic [1:0] {
        TEF_MODE_NORMAL = 2'h0,
        TEF_MODE_DEDUP  = 2'h1,
        TEF_MODE_DETAIL = 2'h2
    } tef_mode_t;

    typedef enum logic [1:0] {
        TEF_ET_EVENT  = 2'h0,
        TEF_ET_VECTOR = 2'h1,
        TEF_ET_SOURCE = 2'h2,
        TEF_ET_DEST   = 2'h3
    } tef_etype_t;

    // change of flow record from the core
    typedef struct packed {
        logic       valid;
        tef_etype_t etype;
        logic [23:0] addr;
        logic       ext_event;
        logic       cmp_match;
        logic       stamp_ovf;
    } tef_cof_t;

    // data access record from the core
    typedef struct packed {
        logic        valid;
        logic [1:0]  size;
        logic        read;
        logic [23:0] addr;
        logic [31:0] data;
    } tef_acc_t;

    // one written trace line
    typedef struct packed {
        logic        valid;
        logic [63:0] data;
        logic [7:0]  counter;
    } tef_line_t;
endpackage

// File: verif/tef_core_model.sv
// core side model: drives flow and access records into the formatter
`timescale 1ns/1ps
module tef_core_model
    import tef_pkg::*;
(
    // clock
    input  wire logic   clk,
    // record stream
    output tef_cof_t    change_of_flow,
    output tef_acc_t    acc,
    output logic        pcv,
    output logic [23:0] pc,
    output logic        cmp,
    output logic        ovf
);
    // quiet stream at time zero
    initial begin
        change_of_flow = '0;
        acc = '0;
        pcv = 1'b0;
        pc  = '0;
        cmp = 1'b0;
        ovf = 1'b0;
    end

    // one flow record, f is {event, comparator, overflow}
    task automatic flow(input tef_etype_t t, input logic [23:0] a, input logic [2:0] f);
        change_of_flow <= {1'b1, t, a, f};
        @(posedge clk);
    endtask

    // one access record, s is {pc valid, pc, comparator, overflow}
    task automatic access(input logic [1:0] sz, input logic rd, input logic [23:0] a,
                          input logic [31:0] d, input logic [26:0] s);
        acc <= {1'b1, sz, rd, a, d};
        {pcv, pc, cmp, ovf} <= s;
        @(posedge clk);
    endtask

    // idle cycle: payload inverted so stale values never look valid
    task automatic idle();
        change_of_flow <= {1'b0, ~change_of_flow[28:0]};
        acc <= {1'b0, ~acc[58:0]};
        pcv <= 1'b0;
        pc  <= ~pc;
        cmp <= ~cmp;
        ovf <= ~ovf;
        @(posedge clk);
    endtask
endmodule

// File: verif/tef_formatter_tb.sv
// self-checking bench of the trace entry formatter
`timescale 1ns/1ps
`include "tef_map.svh"
module tef_formatter_tb;
    import tef_pkg::*;
    logic        clk, rst_n;
    logic [11:0] awaddr, araddr;
    logic [31:0] wdata, rdata, rv;
    logic [3:0]  wstrb;
    logic [1:0]  bresp, rresp;
    logic        awvalid, awready, wvalid, wready, bvalid, bready;
    logic        arvalid, arready, rvalid, rready;
    tef_cof_t    change_of_flow;
    tef_acc_t    acc;
    logic        pcv, cmp, ovf;
    logic [23:0] pc;
    tef_line_t   line;
    tef_line_t   lq[$];
    int          bad_count, cmp_count;
    logic [7:0]  cnt_e;
    logic [4:0]  i;

    tef_formatter DUT (.clk(clk), .rst_n(rst_n), .s_awaddr(awaddr), .s_awvalid(awvalid),
        .s_awready(awready), .s_wdata(wdata), .s_wstrb(wstrb), .s_wvalid(wvalid),
        .s_wready(wready), .s_bresp(bresp), .s_bvalid(bvalid), .s_bready(bready),
        .s_araddr(araddr), .s_arvalid(arvalid), .s_arready(arready), .s_rdata(rdata),
        .s_rresp(rresp), .s_rvalid(rvalid), .s_rready(rready), .cof_in(change_of_flow), .acc_in(acc),
        .pc_valid(pcv), .pc_value(pc), .ts_cmp_match(cmp), .ts_ovf(ovf), .line_out(line));
    tef_core_model core (.clk(clk), .change_of_flow(change_of_flow), .acc(acc), .pcv(pcv), .pc(pc), .cmp(cmp),
        .ovf(ovf));

    always #4 clk = ~clk;

    // collect every written line, checked later in order
    always @(posedge clk) begin
        if (line.valid === 1'b1) lq.push_back(line);
    end

    task automatic finish_test();
        if (bad_count == 0 && cmp_count > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
        cmp_count++;
        if (g !== e) begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask

    // next line against expected bits under mask, counter advanced by st
    task automatic cmp_line(input logic [63:0] e, input logic [63:0] m, input logic [7:0] st);
        tef_line_t g;
        int        n;
        n = 0;
        cnt_e = cnt_e + st;
        while (lq.size() == 0 && n < 40) begin
            @(posedge clk);
            n++;
        end
        g = (lq.size() == 0) ? {1'b0, ~e, ~cnt_e} : lq.pop_front();
        chk("line data", e & m, g.data & m);
        chk("line counter", {56'h0, cnt_e}, {56'h0, g.counter});
    endtask

    // address and data go out together; bready stays high throughout
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic aw_ok, w_ok;
        int   n;
        aw_ok = 1'b0;
        w_ok = 1'b0;
        n = 0;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        do begin
            @(posedge clk);
            if (awvalid && awready) begin
                aw_ok = 1'b1;
                awvalid <= 1'b0;
            end
            if (wvalid && wready) begin
                w_ok = 1'b1;
                wvalid <= 1'b0;
            end
            n++;
        end while (!(aw_ok && w_ok && bvalid === 1'b1) && n < 60);
        chk("bresp", 64'h0, {62'h0, bresp});
        if (n >= 60) bad_count++;
    endtask

    task automatic rd(input logic [11:0] a, output logic [31:0] d);
        int n;
        n = 0;
        araddr <= a;
        arvalid <= 1'b1;
        do begin
            @(posedge clk);
            if (arvalid && arready) arvalid <= 1'b0;
            n++;
        end while (!(rvalid === 1'b1 && !arvalid) && n < 60);
        d = rdata;
        chk("rresp", 64'h0, {62'h0, rresp});
        if (n >= 60) bad_count++;
    endtask

    // flow entry: info byte over address
    function automatic logic [31:0] ent(logic [1:0] t, logic [2:0] f, logic [23:0] a);
        return {t, 2'b00, f[1], f[2], 1'b0, f[0], a};
    endfunction

    // detail line: lanes from low address bits, wrapping, untouched lanes zero
    function automatic logic [63:0] det(logic [1:0] sz, logic r, logic [23:0] a,
                                        logic [31:0] d);
        logic [31:0] ln;
        int          p;
        ln = '0;
        for (int k = 0; k <= sz; k++) begin
            p = 3 - ((a[1:0] + k) % 4);
            ln[p*8 +: 8] = d[31-8*k -: 8];
        end
        return {ln, sz, r, 5'h00, a};
    endfunction

    initial begin
        repeat (5000) @(posedge clk);
        bad_count++;
        finish_test();
    end

    initial begin
        clk = 1'b0;
        rst_n = 1'b0;
        {awaddr, araddr, wdata, awvalid, wvalid, arvalid} = '0;
        wstrb = 4'hf;
        bready = 1'b1;
        rready = 1'b1;
        bad_count = 0;
        cmp_count = 0;
        cnt_e = 8'h00;
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        // reset values, unmapped place ignored
        rd(`TEF_CTRL_OFS, rv);
        chk("ctrl", 64'h0, {32'h0, rv});
        wr(12'hffc, 32'hffff_ffff);
        rd(12'hffc, rv);
        chk("unmapped", 64'h0, {32'h0, rv});
        // normal mode: every entry type, flags varied, event with flow in one entry
        for (i = 0; i < 4; i++) core.flow(tef_etype_t'(i[1:0]), {20'ha5c3e, 2'b01, i[1:0]},
            {i == 0 || i == 3, i[0], i[1]});
        core.idle();
        for (i = 0; i < 4; i += 2) cmp_line({ent(i[1:0] + 2'h1, {i == 2, 1'b1, i[1]},
            {20'ha5c3e, 2'b01, i[1:0] + 2'h1}), ent(i[1:0], {i == 0, 1'b0, i[1]},
            {20'ha5c3e, 2'b01, i[1:0]})}, '1, 8'h2);
        // dedup mode: repeated source dropped, repeated dest and vector kept
        wr(`TEF_CTRL_OFS, 32'h1);
        core.flow(TEF_ET_SOURCE, 24'h004410, 3'b000);
        core.flow(TEF_ET_SOURCE, 24'h004410, 3'b000);
        core.flow(TEF_ET_DEST, 24'h005520, 3'b000);
        core.flow(TEF_ET_DEST, 24'h005520, 3'b000);
        core.flow(TEF_ET_VECTOR, 24'h00fff2, 3'b001);
        core.flow(TEF_ET_VECTOR, 24'h00fff2, 3'b001);
        core.flow(TEF_ET_SOURCE, 24'h004430, 3'b010);
        core.idle();
        cmp_line({ent(2'h3, 3'b000, 24'h005520), ent(2'h2, 3'b000, 24'h004410)}, '1, 8'h2);
        cmp_line({ent(2'h1, 3'b001, 24'h00fff2), ent(2'h3, 3'b000, 24'h005520)}, '1, 8'h2);
        cmp_line({ent(2'h2, 3'b010, 24'h004430), ent(2'h1, 3'b001, 24'h00fff2)}, '1, 8'h2);
        rd(`TEF_STAT_OFS, rv);
        chk("dropped", 64'h1, {32'h0, rv});
        // detail mode: every size at every lane, back to back
        wr(`TEF_CTRL_OFS, 32'h2);
        for (i = 0; i < 16; i++) core.access(i[3:2], i[0], {20'h3c1a5, i[3:0]},
            32'hc1d2e3f4 ^ {4{3'h0, i}}, 27'h0);
        core.idle();
        for (i = 0; i < 16; i++) cmp_line(det(i[3:2], i[0], {20'h3c1a5, i[3:0]},
            32'hc1d2e3f4 ^ {4{3'h0, i}}), '1, 8'h2);
        rd(`TEF_CNT_OFS, rv);
        chk("stamp running", 64'h1, {63'h0, rv[31:16] > 16'h0028});
        chk("count reg", {56'h0, cnt_e}, {56'h0, rv[7:0]});
        // stamps: lone access gets a stamp line, back to back suppresses one
        wr(`TEF_CTRL_OFS, 32'h6);
        core.access(2'b11, 1'b0, 24'h200000, 32'h89abcdef, {1'b1, 24'h0abc12, 2'b10});
        core.idle();
        core.idle();
        core.access(2'b01, 1'b1, 24'h210002, 32'h5a6b0000, {1'b0, 24'h000000, 2'b01});
        core.access(2'b00, 1'b0, 24'h210003, 32'h77000000, {1'b1, 24'h0c0d0e, 2'b01});
        core.idle();
        cmp_line(det(2'b11, 1'b0, 24'h200000, 32'h89abcdef), '1, 8'h2);
        cmp_line({24'h0, 8'h0e, 24'h0abc12}, 64'h0000ffff_ffffffff, 8'h2);
        cmp_line(det(2'b01, 1'b1, 24'h210002, 32'h5a6b0000), '1, 8'h2);
        cmp_line(det(2'b00, 1'b0, 24'h210003, 32'h77000000), '1, 8'h2);
        cmp_line({24'h0, 8'h07, 24'h0c0d0e}, 64'h0000ffff_ffffffff, 8'h2);
        rd(`TEF_CNT_OFS, rv);
        chk("stamp restarted", 64'h1, {63'h0, rv[31:16] < 16'h0028});
        chk("count reg", {56'h0, cnt_e}, {56'h0, rv[7:0]});
        // mode 3 traces nothing and leaves the counter alone
        wr(`TEF_CTRL_OFS, 32'h7);
        core.flow(TEF_ET_DEST, 24'h006600, 3'b000);
        core.access(2'b11, 1'b1, 24'h220000, 32'h01020304, 27'h0);
        core.idle();
        rd(`TEF_CNT_OFS, rv);
        chk("count held", {56'h0, cnt_e}, {56'h0, rv[7:0]});
        chk("no extra lines", 64'h0, 64'(lq.size()));
        finish_test();
    end
endmodule
